//--- core/fpc_convert.sv
// Conversion datapath: float to and from fixed point, double to and from single.
// Assumes the register file answers a read in the cycle the read is shown.
`timescale 1ns/1ps
`default_nettype none
module fpc_convert (
  // Clock and reset.
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Configuration pin: single-precision-only variant.
  input  wire logic             i_sp_only,
  // Request from the decoder.
  input  wire logic             i_valid,
  input  wire fpc_pkg::fpc_instr_t i_instr,
  output logic                  o_ready,
  // Register file port.
  output fpc_pkg::fpc_read_t    o_rd,
  input  wire logic [63:0]      i_rd_data,
  output fpc_pkg::fpc_result_t  o_res
);
  typedef enum logic {ST_IDLE, ST_EXEC} fpc_state_t;

  fpc_state_t          state_reg;
  fpc_pkg::fpc_instr_t cur_reg;
  logic                undef_reg;
  logic [4:0]          dst_idx_reg;
  logic                sp_s1_reg;
  logic                sp_s2_reg;
  logic                accept;

  // Leading one position of a nonzero word.
  function automatic logic [4:0] fpc_lead1(input logic [31:0] v);
    fpc_lead1 = 5'h00;
    for (int k = 0; k < 32; k++) begin
      if (v[k]) fpc_lead1 = 5'(k);
    end
  endfunction

  // Round to nearest even, keeping 24 or 53 leading bits.
  function automatic logic [24:0] fpc_rnd24(input logic [63:0] n);
    fpc_rnd24 = {1'b0, n[63:40]} + {24'h0, n[39] & (n[40] | (|n[38:0]))};
  endfunction
  function automatic logic [53:0] fpc_rnd53(input logic [63:0] n);
    fpc_rnd53 = {1'b0, n[63:11]} + {53'h0, n[10] & (n[11] | (|n[9:0]))};
  endfunction

  assign accept = i_valid & o_ready;

  // The strap comes from outside, so it is synchronised before use.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sp_s1_reg <= 1'b0;
      sp_s2_reg <= 1'b0;
    end else begin
      sp_s1_reg <= i_sp_only;
      sp_s2_reg <= sp_s1_reg;
    end
  end

  // Request capture, index formation and the two-state sequence.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg   <= ST_IDLE;
      o_ready     <= 1'b0;
      o_rd        <= '0;
      cur_reg     <= '0;
      undef_reg   <= 1'b0;
      dst_idx_reg <= 5'h00;
    end else if (state_reg == ST_IDLE) begin
      o_ready <= 1'b1;
      o_rd.req <= 1'b0;
      if (accept) begin
        state_reg <= ST_EXEC;
        o_ready   <= 1'b0;
        cur_reg   <= i_instr;
        if (i_instr.kind == fpc_pkg::FPC_KIND_FIXED) begin
          undef_reg <= 1'b0;
          o_rd.req  <= 1'b1;
          o_rd.dp   <= i_instr.precision_select;
          // Same register is source and destination.
          o_rd.idx  <= i_instr.precision_select ?
                       {i_instr.dest_ext_bit, i_instr.dest_reg_field} :
                       {i_instr.dest_reg_field, i_instr.dest_ext_bit};
          dst_idx_reg <= i_instr.precision_select ?
                       {i_instr.dest_ext_bit, i_instr.dest_reg_field} :
                       {i_instr.dest_reg_field, i_instr.dest_ext_bit};
        end else begin
          undef_reg <= sp_s2_reg;
          o_rd.req  <= ~sp_s2_reg;
          o_rd.dp   <= i_instr.source_precision_bit;
          o_rd.idx  <= i_instr.source_precision_bit ?
                       {i_instr.src_ext_bit, i_instr.src_reg_field} :
                       {i_instr.src_reg_field, i_instr.src_ext_bit};
          dst_idx_reg <= i_instr.source_precision_bit ?
                       {i_instr.dest_reg_field, i_instr.dest_ext_bit} :
                       {i_instr.dest_ext_bit, i_instr.dest_reg_field};
        end
      end
    end else begin
      state_reg <= ST_IDLE;
      o_ready   <= 1'b1;
      o_rd.req  <= 1'b0;
    end
  end

  // Operand unpacking shared by every path except fixed to float, which reads i_rd_data directly.
  logic               src_dp;
  logic               u_sign;
  logic [10:0]        u_exp;
  logic [51:0]        u_frac;
  logic [52:0]        mant53;
  logic               u_den;
  logic               u_zero;
  logic               u_inf;
  logic               u_nan;
  logic               u_snan;
  logic signed [13:0] u_e;
  logic [10:0]        exp_all;

  assign src_dp  = (cur_reg.kind == fpc_pkg::FPC_KIND_FIXED) ?
                   cur_reg.precision_select : cur_reg.source_precision_bit;
  assign u_sign  = src_dp ? i_rd_data[63] : i_rd_data[31];
  assign u_exp   = src_dp ? i_rd_data[62:52] : {3'h0, i_rd_data[30:23]};
  assign u_frac  = src_dp ? i_rd_data[51:0] : {i_rd_data[22:0], 29'h0};
  assign exp_all = src_dp ? fpc_pkg::FPC_DP_EXP_ALL : fpc_pkg::FPC_SP_EXP_ALL;
  assign mant53  = {1'b1, u_frac};
  assign u_zero  = (u_exp == 11'h000);
  assign u_den   = u_zero & (|u_frac);
  assign u_inf   = (u_exp == exp_all) & ~(|u_frac);
  assign u_nan   = (u_exp == exp_all) & (|u_frac);
  assign u_snan  = u_nan & ~u_frac[51];
  assign u_e     = $signed({3'h0, u_exp}) - $signed({1'b0, src_dp ?
                   fpc_pkg::FPC_DP_BIAS : fpc_pkg::FPC_SP_BIAS});

  // Fixed-point width and fraction count; a negative count is taken as 0.
  logic [5:0]         fx_size;
  logic signed [13:0] fx_fb_raw;
  logic signed [13:0] fx_fb;
  logic [63:0]        fx_mask;
  assign fx_size   = cur_reg.fixed_width_select ? fpc_pkg::FPC_FX_WIDE :
                     fpc_pkg::FPC_FX_NARROW;
  assign fx_fb_raw = $signed({8'h00, fx_size}) - $signed({9'h000,
                     cur_reg.immediate_high_field, cur_reg.imm_low_bit});
  assign fx_fb     = fx_fb_raw[13] ? 14'sh0000 : fx_fb_raw;
  assign fx_mask   = (fpc_pkg::FPC_ONE64 << fx_size) - fpc_pkg::FPC_ONE64;

  // Float toward_integer_flag: a right shift truncates, which is round toward zero.
  logic signed [13:0] tf_rs;
  logic [5:0]         tf_sh;
  logic [63:0]        tf_m64;
  logic [63:0]        tf_mag;
  logic               tf_lost;
  logic [63:0]        tf_lim;
  logic               tf_ovf;
  logic [63:0]        tf_val;
  logic [63:0]        tf_ext;
  assign tf_rs   = fpc_pkg::FPC_DP_FRAC_W - u_e - fx_fb;
  assign tf_sh   = tf_rs[5:0];
  assign tf_m64  = {11'h000, mant53};
  assign tf_mag  = (tf_rs >= fpc_pkg::FPC_SHIFT_OUT) ? 64'h0 :
                   (tf_m64 >> tf_sh);
  assign tf_lost = (tf_rs >= fpc_pkg::FPC_SHIFT_OUT) |
                   (|(tf_m64 & ~({64{1'b1}} << tf_sh)));
  // A negative value has no unsigned form, so its limit is zero.
  assign tf_lim  = cur_reg.unsigned_sel ? (u_sign ? 64'h0 : fx_mask) :
                   (u_sign ? (fpc_pkg::FPC_ONE64 << (fx_size - 6'h01)) :
                   (fx_mask >> 1));
  assign tf_ovf  = u_inf | (tf_rs <= 14'sh0000) | (tf_mag > tf_lim);
  assign tf_val  = (u_sign & ~cur_reg.unsigned_sel) ?
                   (~(tf_ovf ? tf_lim : tf_mag) + fpc_pkg::FPC_ONE64) :
                   (tf_ovf ? tf_lim : tf_mag);
  assign tf_ext  = (~cur_reg.unsigned_sel & tf_val[fx_size - 6'h01]) ?
                   ((tf_val & fx_mask) | ~fx_mask) :
                   (tf_val & fx_mask);

  // Fixed to float: only the low fixed-width bits are looked at.
  logic [31:0]        ff_raw;
  logic               ff_neg;
  logic [31:0]        ff_mag;
  logic [4:0]         ff_p;
  logic [63:0]        ff_norm;
  logic signed [13:0] ff_e;
  logic [24:0]        ff24;
  logic [53:0]        ff53;
  assign ff_raw  = i_rd_data[31:0] & fx_mask[31:0];
  assign ff_neg  = ~cur_reg.unsigned_sel & ff_raw[5'(fx_size - 6'h01)];
  assign ff_mag  = ff_neg ? (~(ff_raw | ~fx_mask[31:0]) + 32'h1) : ff_raw;
  assign ff_p    = fpc_lead1(ff_mag);
  assign ff_norm = {ff_mag, 32'h0} << (5'h1F - ff_p);
  assign ff_e    = $signed({9'h000, ff_p}) - fx_fb;
  assign ff24    = fpc_rnd24(ff_norm);
  assign ff53    = fpc_rnd53(ff_norm);

  // Narrowing rounds to nearest like any arithmetic result.
  logic [24:0]        nr;
  logic signed [13:0] nr_e;
  assign nr   = fpc_rnd24({mant53, 11'h000});
  assign nr_e = u_e + {13'h0000, nr[24]};

  // Result selection and exception flags.
  logic [63:0]         x_data;
  fpc_pkg::fpc_flags_t x_fl;
  logic                x_dp;
  always_comb begin
    x_data = 64'h0;
    x_fl   = '0;
    x_dp   = cur_reg.precision_select;
    if (cur_reg.kind == fpc_pkg::FPC_KIND_FIXED) begin
      if (cur_reg.direction_bit) begin
        // Toward fixed point: only invalid, denormal and inexact arise.
        if (u_nan) begin
          x_fl.invalid = 1'b1;
        end else if (u_zero) begin
          x_fl.in_denorm = u_den;
        end else begin
          x_fl.invalid = tf_ovf;
          x_fl.inexact = ~tf_ovf & tf_lost;
          x_data = cur_reg.precision_select ? tf_ext : {32'h0, tf_ext[31:0]};
        end
      end else if (ff_mag != 32'h0) begin
        x_fl.inexact = cur_reg.precision_select ? (|ff_norm[10:0]) :
                       (|ff_norm[39:0]);
        if (cur_reg.precision_select) begin
          x_data = {ff_neg, 11'(ff_e + {1'b0, fpc_pkg::FPC_DP_BIAS}
                   + {13'h0000, ff53[53]}),
                    ff53[53] ? ff53[52:1] : ff53[51:0]};
        end else begin
          x_data = {32'h0, ff_neg, 8'(ff_e + {1'b0, fpc_pkg::FPC_SP_BIAS}
                   + {13'h0000, ff24[24]}),
                    ff24[24] ? ff24[23:1] : ff24[22:0]};
        end
      end
    end else if (cur_reg.source_precision_bit) begin
      x_dp = 1'b0;
      if (u_nan) begin
        x_fl.invalid = u_snan;
        // The quiet bit plus the top 22 payload bits fill the 23-bit field.
        x_data = {32'h0, u_sign, 8'hFF, 1'b1, u_frac[50:29]};
      end else if (u_inf) begin
        x_data = {32'h0, u_sign, 8'hFF, 23'h0};
      end else if (u_zero) begin
        x_fl.in_denorm = u_den;
        x_data = {32'h0, u_sign, 31'h0};
      end else if (nr_e > fpc_pkg::FPC_SP_EMAX) begin
        x_fl.overflow = 1'b1;
        x_fl.inexact  = 1'b1;
        x_data = {32'h0, u_sign, 8'hFF, 23'h0};
      end else if (nr_e < fpc_pkg::FPC_SP_EMIN) begin
        // Tiny results flush to zero; no denormal outputs are built.
        x_fl.underflow = 1'b1;
        x_fl.inexact   = 1'b1;
        x_data = {32'h0, u_sign, 31'h0};
      end else begin
        x_fl.inexact = |u_frac[28:0];
        x_data = {32'h0, u_sign, 8'(nr_e + {1'b0, fpc_pkg::FPC_SP_BIAS}),
                  nr[24] ? nr[23:1] : nr[22:0]};
      end
    end else begin
      x_dp = 1'b1;
      if (u_nan) begin
        x_fl.invalid = u_snan;
        x_data = {u_sign, 11'h7FF, 1'b1, u_frac[50:0]};
      end else if (u_inf) begin
        x_data = {u_sign, 11'h7FF, 52'h0};
      end else if (u_zero) begin
        x_fl.in_denorm = u_den;
        x_data = {u_sign, 63'h0};
      end else begin
        x_data = {u_sign, 11'(u_e + {1'b0, fpc_pkg::FPC_DP_BIAS}), u_frac};
      end
    end
  end

  // Completion; an undefined request writes nothing and raises no flags.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_res <= '0;
    end else if (state_reg == ST_EXEC) begin
      o_res.done  <= 1'b1;
      o_res.undef <= undef_reg;
      o_res.wr_en <= ~undef_reg;
      o_res.dp    <= x_dp;
      o_res.idx   <= dst_idx_reg;
      o_res.data  <= undef_reg ? 64'h0 : x_data;
      o_res.flags <= undef_reg ? '0 : x_fl;
    end else begin
      o_res.done  <= 1'b0;
      o_res.undef <= 1'b0;
      o_res.wr_en <= 1'b0;
    end
  end

  property p_sext16;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_res.wr_en && cur_reg.kind == fpc_pkg::FPC_KIND_FIXED &&
     cur_reg.direction_bit && !cur_reg.unsigned_sel &&
     !cur_reg.fixed_width_select)
    |-> (o_res.data[31:16] == {16{o_res.data[15]}});
  endproperty
  a_sext16: assert property (p_sext16) else $error("16-bit sign fill");
  property p_sext64;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_res.wr_en && cur_reg.kind == fpc_pkg::FPC_KIND_FIXED &&
     cur_reg.direction_bit && !cur_reg.unsigned_sel && o_res.dp)
    |-> (o_res.data[63:32] == {32{o_res.data[31]}});
  endproperty
  a_sext64: assert property (p_sext64) else $error("64-bit sign fill");
  property p_zext;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_res.wr_en && cur_reg.kind == fpc_pkg::FPC_KIND_FIXED &&
     cur_reg.direction_bit && cur_reg.unsigned_sel &&
     !cur_reg.fixed_width_select) |-> (o_res.data[63:16] == 48'h0);
  endproperty
  a_zext: assert property (p_zext) else $error("zero fill wrong");
  property p_fix_flags;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_res.done && cur_reg.kind == fpc_pkg::FPC_KIND_FIXED)
    |-> !o_res.flags.overflow && !o_res.flags.underflow;
  endproperty
  a_fix_flags: assert property (p_fix_flags) else $error("bad flag");
  property p_from_fixed;
    @(posedge i_clk_sys) disable iff (i_rst)
    (o_res.done && cur_reg.kind == fpc_pkg::FPC_KIND_FIXED &&
     !cur_reg.direction_bit) |-> !o_res.flags.invalid && !o_res.flags.in_denorm;
  endproperty
  a_from_fixed: assert property (p_from_fixed) else $error("fx flag");
  property p_fix_idx;
    @(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_instr.kind == fpc_pkg::FPC_KIND_FIXED &&
     !i_instr.precision_select)
    |=> (o_rd.idx == {$past(i_instr.dest_reg_field),
                      $past(i_instr.dest_ext_bit)}) ##1 (o_res.idx == o_rd.idx);
  endproperty
  a_fix_idx: assert property (p_fix_idx) else $error("fixed index");
  property p_narrow;
    @(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_instr.kind == fpc_pkg::FPC_KIND_PREC && !sp_s2_reg &&
     i_instr.source_precision_bit)
    |=> (o_rd.idx == {$past(i_instr.src_ext_bit), $past(i_instr.src_reg_field)})
    ##1 (o_res.wr_en && !o_res.dp && o_res.idx ==
         {$past(i_instr.dest_reg_field, 2), $past(i_instr.dest_ext_bit, 2)});
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow index");
  property p_widen;
    @(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_instr.kind == fpc_pkg::FPC_KIND_PREC && !sp_s2_reg &&
     !i_instr.source_precision_bit) |-> ##2 (o_res.wr_en && o_res.dp);
  endproperty
  a_widen: assert property (p_widen) else $error("widen precision");
  property p_sp_only;
    @(posedge i_clk_sys) disable iff (i_rst)
    (accept && i_instr.kind == fpc_pkg::FPC_KIND_PREC && sp_s2_reg)
    |-> ##1 !o_rd.req ##1 (o_res.undef && !o_res.wr_en);
  endproperty
  a_sp_only: assert property (p_sp_only) else $error("not undefined");
endmodule
`default_nettype wire

//--- core/fpc_pkg.sv
// Constants and carrier types for the fixed-point and precision converter.
// Assumes one core clock; the decoder and register file share that clock.
package fpc_pkg;
  localparam logic [5:0]         FPC_FX_NARROW = 6'h10;
  localparam logic [5:0]         FPC_FX_WIDE   = 6'h20;
  localparam logic [12:0]        FPC_SP_BIAS   = 13'h007F;
  localparam logic [12:0]        FPC_DP_BIAS   = 13'h03FF;
  localparam logic [10:0]        FPC_SP_EXP_ALL = 11'h0FF;
  localparam logic [10:0]        FPC_DP_EXP_ALL = 11'h7FF;
  localparam logic signed [13:0] FPC_DP_FRAC_W = 14'sh0034;
  localparam logic signed [13:0] FPC_SHIFT_OUT = 14'sh0040;
  localparam logic signed [13:0] FPC_SP_EMAX   = 14'sh007F;
  localparam logic signed [13:0] FPC_SP_EMIN   = 14'sh3F82;
  localparam logic [63:0]        FPC_ONE64     = 64'h1;

  typedef enum logic {FPC_KIND_FIXED, FPC_KIND_PREC} fpc_kind_t;

  // One decoded conversion request from the instruction decoder.
  typedef struct packed {
    fpc_kind_t  kind;
    logic       direction_bit;
    logic       precision_select;
    logic       unsigned_sel;
    logic       fixed_width_select;
    logic [3:0] immediate_high_field;
    logic       imm_low_bit;
    logic [3:0] dest_reg_field;
    logic       dest_ext_bit;
    logic [3:0] src_reg_field;
    logic       src_ext_bit;
    logic       source_precision_bit;
  } fpc_instr_t;

  typedef struct packed {
    logic invalid;
    logic overflow;
    logic underflow;
    logic inexact;
    logic in_denorm;
  } fpc_flags_t;

  // Register file read request.
  typedef struct packed {
    logic       req;
    logic       dp;
    logic [4:0] idx;
  } fpc_read_t;

  // Completion and register file write.
  typedef struct packed {
    logic       done;
    logic       undef;
    logic       wr_en;
    logic       dp;
    logic [4:0] idx;
    logic [63:0] data;
    fpc_flags_t flags;
  } fpc_result_t;
endpackage

//--- test/fpc_regfile_model.sv
// Register file partner for the converter: separate single and double banks.
// Assumes the converter's registered read request and write-back outputs.
`timescale 1ns/1ps
`default_nettype none
module fpc_regfile_model (
  // Clock.
  input  wire logic                 i_clk_sys,
  // Converter side.
  input  wire fpc_pkg::fpc_read_t   i_rd,
  input  wire fpc_pkg::fpc_result_t i_res,
  output logic [63:0]               o_rd_data
);
  logic [63:0] dbank [32];
  logic [31:0] sbank [32];
  logic [63:0] last_reg = 64'h0;

  // Preload used by the bench before it issues a request.
  task automatic load(input logic dp, input logic [4:0] idx,
                      input logic [63:0] v);
    if (dp)
      dbank[idx] = v;
    else
      sbank[idx] = v[31:0];
  endtask

  // Data is valid only while a read is requested; otherwise the bus shows
  // the inverse of its last value so stale data never looks correct.
  always_comb begin
    if (!i_rd.req)
      o_rd_data = ~last_reg;
    else if (i_rd.dp)
      o_rd_data = dbank[i_rd.idx];
    else
      o_rd_data = {~last_reg[63:32], sbank[i_rd.idx]};
  end

  // Write-back of results and memory of the last value shown.
  always @(posedge i_clk_sys) begin
    last_reg <= o_rd_data;
    if (i_res.wr_en && i_res.dp)
      dbank[i_res.idx] <= i_res.data;
    if (i_res.wr_en && !i_res.dp)
      sbank[i_res.idx] <= i_res.data[31:0];
  end
endmodule
`default_nettype wire

//--- test/tb_fp_fixed_precision_convert.sv
// Self-checking bench for the fixed-point and precision converter.
// Assumes the register file model answers reads in the requested cycle.
`timescale 1ns/1ps
`default_nettype none
module tb_fp_fixed_precision_convert;
  typedef struct {
    logic        rd;
    logic        rdp;
    logic [4:0]  ridx;
    logic        wdp;
    logic [4:0]  widx;
    logic [63:0] data;
    logic        undef;
    logic [4:0]  flags;
  } fpc_note_t;
  localparam logic [4:0] FL_INV = 5'h10;
  localparam logic [4:0] FL_OVX = 5'h0A;
  localparam logic [4:0] FL_INX = 5'h02;
  localparam logic [4:0] FL_DEN = 5'h01;

  logic                 i_clk_sys = 1'b0;
  logic                 i_rst;
  logic                 i_sp_only;
  logic                 i_valid;
  fpc_pkg::fpc_instr_t  i_instr;
  logic                 o_ready;
  fpc_pkg::fpc_read_t   o_rd;
  logic [63:0]          i_rd_data;
  fpc_pkg::fpc_result_t o_res;
  fpc_note_t            q[$];
  fpc_note_t            mon_note;
  logic                 seen_rd = 1'b0;
  int                   errors = 0;
  int                   checks = 0;

  fpc_convert u_fpc_convert (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_sp_only(i_sp_only), .i_valid(i_valid), .i_instr(i_instr),
    .o_ready(o_ready), .o_rd(o_rd), .i_rd_data(i_rd_data), .o_res(o_res));
  fpc_regfile_model u_fpc_regfile_model (.i_clk_sys(i_clk_sys),
    .i_rd(o_rd), .i_res(o_res), .o_rd_data(i_rd_data));

  // Free-running 200 MHz clock.
  always #2.5 i_clk_sys = ~i_clk_sys;

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Holds the request until an edge sees ready; leaves valid high so a
  // following call makes a back-to-back request that is refused once.
  task automatic send(input fpc_note_t n);
    logic r;
    r = 1'b0;
    q.push_back(n);
    i_valid = 1'b1;
    for (int k = 0; k < 20 && !r; k++) begin
      @(negedge i_clk_sys) r = o_ready;
      @(posedge i_clk_sys);
    end
    #1;
    if (!r) begin
      errors++;
      $display("Error request expected taken seen refused");
    end
  endtask

  task automatic idle();
    i_valid = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic fixed(input logic dir, dp, uns, wid, input logic [4:0] imm,
    input logic [3:0] rf, input logic ext, input logic [63:0] src, res,
    input logic [4:0] fl);
    fpc_note_t n;
    logic [4:0] ix;
    ix = dp ? {ext, rf} : {rf, ext};
    u_fpc_regfile_model.load(dp, ix, src);
    n = '{1'b1, dp, ix, dp, ix, res, 1'b0, fl};
    i_instr = '0;
    i_instr.kind = fpc_pkg::FPC_KIND_FIXED;
    i_instr.direction_bit = dir;
    i_instr.precision_select = dp;
    i_instr.unsigned_sel = uns;
    i_instr.fixed_width_select = wid;
    i_instr.immediate_high_field = imm[4:1];
    i_instr.imm_low_bit = imm[0];
    i_instr.dest_reg_field = rf;
    i_instr.dest_ext_bit = ext;
    send(n);
  endtask

  task automatic prec(input logic spb, input logic [3:0] drf,
    input logic dext, input logic [3:0] srf, input logic sext,
    input logic [63:0] src, res, input logic [4:0] fl, input logic und);
    fpc_note_t n;
    logic [4:0] si;
    logic [4:0] di;
    si = spb ? {sext, srf} : {srf, sext};
    di = spb ? {drf, dext} : {dext, drf};
    u_fpc_regfile_model.load(spb, si, src);
    n = '{!und, spb, si, !spb, di, und ? 64'h0 : res, und, und ? 5'h0 : fl};
    i_instr = '0;
    i_instr.kind = fpc_pkg::FPC_KIND_PREC;
    i_instr.source_precision_bit = spb;
    i_instr.dest_reg_field = drf;
    i_instr.dest_ext_bit = dext;
    i_instr.src_reg_field = srf;
    i_instr.src_ext_bit = sext;
    send(n);
  endtask

  // Watches the outputs at mid-cycle, where registered values have settled,
  // and compares each completion with the oldest note.
  always @(negedge i_clk_sys) begin
    if (o_rd.req) begin
      seen_rd = 1'b1;
      if (q.size() > 0) begin
        chk("read width", 64'(q[0].rdp), 64'(o_rd.dp));
        chk("read index", 64'(q[0].ridx), 64'(o_rd.idx));
      end
    end
    if (o_res.done) begin
      if (q.size() == 0) begin
        errors++;
        $display("Error completion expected none seen one");
      end else begin
        mon_note = q.pop_front();
        chk("read issued", 64'(mon_note.rd), 64'(seen_rd));
        chk("undefined", 64'(mon_note.undef), 64'(o_res.undef));
        chk("write enable", 64'(!mon_note.undef), 64'(o_res.wr_en));
        chk("data", mon_note.data, o_res.data);
        chk("flags", 64'(mon_note.flags), 64'(o_res.flags));
        if (!mon_note.undef) begin
          chk("write width", 64'(mon_note.wdp), 64'(o_res.dp));
          chk("write index", 64'(mon_note.widx), 64'(o_res.idx));
        end
      end
      seen_rd = 1'b0;
    end
  end

  // A hang is cut after well over the expected run length.
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    logic [15:0] rn;
    logic [3:0]  rf;
    i_rst = 1'b1;
    i_sp_only = 1'b0;
    i_valid = 1'b0;
    i_instr = '0;
    void'($urandom(13565));
    repeat (16) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    idle();
    // Back-to-back: the second is refused once, then taken.
    fixed(1'b1, 1'b0, 1'b0, 1'b0, 5'h10, 4'h5, 1'b1, 64'h40700000, 64'h3,
          FL_INX);
    fixed(1'b1, 1'b0, 1'b0, 1'b0, 5'h10, 4'h5, 1'b0, 64'hC0700000,
          64'hFFFFFFFD, FL_INX);
    idle();
    fixed(1'b1, 1'b0, 1'b0, 1'b0, 5'h10, 4'h2, 1'b1, 64'h471C4000,
          64'h7FFF, FL_INV);
    fixed(1'b1, 1'b1, 1'b1, 1'b0, 5'h0C, 4'h5, 1'b1, 64'h4004000000000000,
          64'h28, 5'h0);
    fixed(1'b1, 1'b1, 1'b0, 1'b1, 5'h1F, 4'h3, 1'b0, 64'hBFF8000000000000,
          64'hFFFFFFFFFFFFFFFD, 5'h0);
    fixed(1'b0, 1'b0, 1'b0, 1'b0, 5'h10, 4'h7, 1'b0, 64'h12348000,
          64'hC7000000, 5'h0);
    fixed(1'b0, 1'b0, 1'b1, 1'b1, 5'h1F, 4'h7, 1'b1, 64'h01000003,
          64'h4B000002, FL_INX);
    fixed(1'b0, 1'b1, 1'b0, 1'b1, 5'h00, 4'h9, 1'b1, 64'hDEADBEEF80000000,
          64'hBFE0000000000000, 5'h0);
    fixed(1'b1, 1'b0, 1'b0, 1'b1, 5'h1F, 4'h1, 1'b0, 64'h7F800001, 64'h0,
          FL_INV);
    fixed(1'b1, 1'b0, 1'b0, 1'b1, 5'h1F, 4'h1, 1'b1, 64'h00000001, 64'h0,
          FL_DEN);
    prec(1'b1, 4'h5, 1'b1, 4'h6, 1'b1, 64'h3FF8000000000000, 64'h3FC00000,
         5'h0, 1'b0);
    prec(1'b0, 4'h5, 1'b1, 4'h6, 1'b1, 64'h3FC00000, 64'h3FF8000000000000,
         5'h0, 1'b0);
    prec(1'b1, 4'hA, 1'b0, 4'hC, 1'b0, 64'h7FE0000000000000, 64'h7F800000,
         FL_OVX, 1'b0);
    // A signalling NaN narrows to a quiet NaN and raises invalid.
    prec(1'b1, 4'h3, 1'b0, 4'h2, 1'b1, 64'h7FF0000000000001, 64'h7FC00000,
         FL_INV, 1'b0);
    // Too small for a normal single: flushed, underflow and inexact.
    prec(1'b1, 4'h3, 1'b1, 4'h2, 1'b0, 64'h3800000000000000, 64'h0,
         5'h06, 1'b0);
    idle();
    // Single-precision-only variant: precision conversion is undefined.
    i_sp_only = 1'b1;
    idle();
    prec(1'b1, 4'h5, 1'b1, 4'h6, 1'b1, 64'h3FF8000000000000, 64'h0, 5'h0,
         1'b1);
    fixed(1'b1, 1'b0, 1'b0, 1'b0, 5'h10, 4'h4, 1'b0, 64'h40700000, 64'h3,
          FL_INX);
    idle();
    i_sp_only = 1'b0;
    idle();
    // Random half-way values must truncate, never round up.
    for (int k = 0; k < 8; k++) begin
      rn = 16'($urandom_range(65535));
      rf = 4'($urandom);
      fixed(1'b1, 1'b1, 1'b1, 1'b0, 5'h10, rf, 1'b0,
            $realtobits(real'(rn) + 0.5), 64'(rn), FL_INX);
      idle();
    end
    idle();
    chk("pending notes", 64'h0, 64'(q.size()));
    summarize();
  end
endmodule
`default_nettype wire
